// [sri_chr_if.sv]
// Character stream carrier between the sequencer and the buffer.
// Assumes one clock; a word moves on a cycle with valid and ready both high.
`timescale 1ns/100ps
interface sri_chr_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sri_chr_if

// [sri_fifo2.sv]
// Two-entry character buffer with valid/ready on both sides.
// Assumes synchronous active-high reset and a clock enable that freezes it.
`timescale 1ns/100ps
module sri_fifo2 #(
  parameter int DW = 8,
  parameter int AW = 1
) (
  input wire logic mclk, // Device clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  sri_chr_if.snk wr, // Filling side
  sri_chr_if.src rd // Draining side
);
  import sri_pkg::*;
  localparam int DEPTH = 1 << AW;
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign wr.ready = (cnt != (AW+1)'(DEPTH));
  assign rd.valid = (cnt != '0);
  assign rd.data = mem[rp];
  assign push = ce && wr.valid && wr.ready;
  assign pop = ce && rd.valid && rd.ready;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wp] <= wr.data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
      begin
        wp <= wp + 1'b1;
      end
      if (pop)
      begin
        rp <= rp + 1'b1;
      end
      if (push && !pop)
      begin
        cnt <= cnt + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  property p_full_refuses;
    @(posedge mclk) disable iff (rst)
    (ce && cnt == (AW+1)'(DEPTH) && !rd.ready) |=> !wr.ready && $stable(rd.data);
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("stalled full buffer changed its head word");
endmodule : sri_fifo2

// [sri_host_model.sv]
// Host end of the character link: takes every character the device offers.
// Assumes the device clock; ready stalls at random while stall_en is high.
`timescale 1ns/100ps
module sri_host_model (
  input wire logic mclk, // Device clock
  input wire logic stall_en, // Allow random stalls
  input wire logic line_valid, // Character offered
  input wire logic [7:0] line_data, // Character offered
  output logic line_ready // Host takes the character
);
  logic [7:0] got[$];

  // Both ends run the same character rate, modelled as one transfer per accepted cycle
  always @(negedge mclk)
    line_ready <= stall_en ? ($urandom % 3 != 0) : 1'b1;

  always @(posedge mclk)
    if (line_valid === 1'b1 && line_ready === 1'b1)
      got.push_back(line_data);
endmodule : sri_host_model

// [sri_pkg.sv]
// Package of the serial register readout block: character codes, field layout, timing.
// Assumes a 10 MHz device clock; sri_fifo2, sri_readout, sri_tick and the bench import it.
package sri_pkg;
  localparam int CHW = 8;
  localparam int CODEW = 16;
  localparam int DIGITS = 6;
  localparam int VALW = 24;
  localparam int TMRW = 14;
  localparam int BAUDW = 3;
  localparam int BITCW = 16;

  localparam logic [7:0] CH_EOT = 8'h04;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CODE_CH_MAX = 8'h3F;

  localparam logic [3:0] ADDR_DEF_TENS = 4'h1;
  localparam logic [3:0] ADDR_DEF_ONES = 4'h1;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [2:0] LAST_DIGIT = 3'h5;

  // Serial timer, in milliseconds
  localparam logic [TMRW-1:0] TIMER_MIN_MS = 14'h000A;
  localparam int TICK_TIME_NS = 1000000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_HZ = 10000000;
  localparam int MS_CYC = TICK_TIME_NS / CLK_PERIOD_NS;

  localparam int BAUD_RATE [0:6] = '{600, 1200, 2400, 4800, 9600, 19200, 38400};
  localparam logic [BAUDW-1:0] BAUD_SEL_DEF = 3'h4;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00000,
    S_ADDRH = 5'b00001,
    S_ADDRL = 5'b00010,
    S_CODEH = 5'b00011,
    S_CODEL = 5'b00100,
    S_ENQ = 5'b00101,
    S_STX = 5'b00110,
    S_C1 = 5'b00111,
    S_C2 = 5'b01000,
    S_SPACE = 5'b01001,
    S_SIGN = 5'b01010,
    S_DIGIT = 5'b01011,
    S_ETX = 5'b01100,
    S_BCC = 5'b01101,
    S_LF = 5'b01110,
    S_CR = 5'b01111,
    S_EOT = 5'b10000,
    S_NAK = 5'b10001
  } sri_state_e;
endpackage : sri_pkg

// [sri_readout.sv]
// Serial register readout: parses addressed read requests, answers them,
// and emits printer lines on a timer or a trigger.
// Assumes characters arrive and leave through an external character link.
// Functional notes
// - A request is EOT, two address chars, two register-code chars, then ENQ.
// - Address and code digits each travel as one ASCII character.
// - A good request is answered with STX, the two code chars, the value, ETX and a check char.
// - Leading zero digits of the value are left out of a response.
// - The check char is the XOR of every char from the first code char through ETX.
// - A bad request gets STX, code chars and EOT, or a single NAK, and never data.
// - In PC mode any register named by the request code can be read.
// - In printer mode the register chosen by the print-code setting is sent unasked.
// - The line format is either space, sign, six digits, LF, CR or sign, six digits, CR.
// - A timer of 0.010 s or more sends lines cyclically once configuration is left.
// - A timer of zero sends one line per enter press or trigger rising edge.
// - The unit address runs 11 to 99 and never holds a zero digit.
// - The link runs at one of seven rates from 600 to 38400 baud, equal at both ends.
`timescale 1ns/100ps
module sri_readout #(
  parameter int MS_CYC_P = sri_pkg::MS_CYC,
  parameter int CLK_HZ_P = sri_pkg::CLK_HZ
) (
  input wire logic mclk, // Device clock, 10 MHz
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic rx_valid, // Received character strobe
  input wire logic [sri_pkg::CHW-1:0] rx_data, // Received character
  output logic line_valid, // Character to send
  output logic [sri_pkg::CHW-1:0] line_data, // Character to send
  input wire logic line_ready, // Link takes the character
  input wire logic pc_mode, // 1: PC mode, 0: printer mode
  input wire logic compact_line_format, // Printer format select
  input wire logic [sri_pkg::CODEW-1:0] print_code, // Register for printer lines
  input wire logic [sri_pkg::TMRW-1:0] timer_ms, // Serial timer in ms
  input wire logic cfg_active, // Configuration menu open
  input wire logic enter_key, // Enter key level
  input wire logic trig_in, // External trigger level
  input wire logic [3:0] unit_addr_tens, // Unit address high digit
  input wire logic [3:0] unit_addr_ones, // Unit address low digit
  input wire logic [sri_pkg::BAUDW-1:0] baud_sel, // Link rate select
  output logic [sri_pkg::BITCW-1:0] bit_cycles, // Clocks per link bit
  output logic [sri_pkg::CODEW-1:0] reg_code, // Register being read
  input wire logic reg_ok, // Register code exists
  input wire logic reg_neg, // Register value negative
  input wire logic [sri_pkg::VALW-1:0] reg_bcd, // Register value, six BCD digits
  output logic busy // Sequencer active
);
  import sri_pkg::*;

  sri_state_e state;
  sri_state_e next_state;
  sri_chr_if chr ();
  sri_chr_if lnk ();

  logic [7:0] addr_high_char;
  logic [7:0] addr_low_char;
  logic [7:0] regcode_high_char;
  logic [7:0] regcode_low_char;
  logic [VALW-1:0] val;
  logic neg;
  logic is_print;
  logic is_err;
  logic [2:0] idx;
  logic [7:0] bcc;
  logic pend;
  logic enter_q;
  logic trig_q;
  logic tick;
  logic manual_ev;
  logic launch_print;
  logic rx_fire;
  logic wr_fire;
  logic tx_state;
  logic addr_hit;
  logic code_ok;
  logic [3:0] own_tens;
  logic [3:0] own_ones;
  logic [2:0] first_nz;
  logic [7:0] tx_char;

  function automatic logic [2:0] lead_digit(input logic [VALW-1:0] v);
    logic [2:0] r;
    r = LAST_DIGIT;
    for (int i = 0; i < DIGITS; i++)
    begin
      if (v[i*4 +: 4] != 4'h0)
      begin
        r = 3'(DIGITS - 1 - i);
      end
    end
    return r;
  endfunction : lead_digit

  function automatic logic is_code_char(input logic [7:0] c);
    return (c >= CH_ZERO) && (c <= CODE_CH_MAX);
  endfunction : is_code_char

  // An address with a zero digit cannot be ours; fall back to the default
  assign own_tens = (unit_addr_tens == 4'h0 || unit_addr_tens > DIGIT_MAX ||
                     unit_addr_ones == 4'h0 || unit_addr_ones > DIGIT_MAX) ? ADDR_DEF_TENS : unit_addr_tens;
  assign own_ones = (own_tens == ADDR_DEF_TENS && unit_addr_tens != ADDR_DEF_TENS) ||
                    unit_addr_ones == 4'h0 || unit_addr_ones > DIGIT_MAX ? ADDR_DEF_ONES : unit_addr_ones;

  // A zero digit in a request addresses every unit in that place
  assign addr_hit = (addr_high_char == CH_ZERO || addr_high_char == (CH_ZERO | {4'h0, own_tens})) &&
                    (addr_low_char == CH_ZERO || addr_low_char == (CH_ZERO | {4'h0, own_ones}));
  assign code_ok = is_code_char(regcode_high_char) && is_code_char(regcode_low_char) && reg_ok;
  assign first_nz = lead_digit(val);

  assign rx_fire = ce && rx_valid && pc_mode && !tx_state;
  assign tx_state = (state >= S_STX);
  assign wr_fire = ce && tx_state && chr.ready;
  assign busy = (state != S_IDLE);
  assign launch_print = ce && (state == S_IDLE) && pend && !pc_mode && !cfg_active;
  assign manual_ev = (timer_ms == '0) && !cfg_active && !pc_mode &&
                     ((enter_key && !enter_q) || (trig_in && !trig_q));

  always_comb
  begin
    unique case (state)
      S_STX: tx_char = CH_STX;
      S_C1: tx_char = regcode_high_char;
      S_C2: tx_char = regcode_low_char;
      S_SPACE: tx_char = CH_SPACE;
      S_SIGN: tx_char = neg ? CH_MINUS : CH_PLUS;
      S_DIGIT: tx_char = CH_ZERO | {4'h0, val[(DIGITS - 1 - 32'(idx))*4 +: 4]};
      S_ETX: tx_char = CH_ETX;
      S_BCC: tx_char = bcc;
      S_LF: tx_char = CH_LF;
      S_CR: tx_char = CH_CR;
      S_EOT: tx_char = CH_EOT;
      S_NAK: tx_char = CH_NAK;
      default: tx_char = 8'h00;
    endcase
  end

  assign chr.valid = tx_state;
  assign chr.data = tx_char;
  assign line_valid = lnk.valid;
  assign line_data = lnk.data;
  assign lnk.ready = line_ready;

  sri_fifo2 #(.DW(CHW), .AW(1)) u_buf (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wr(chr),
    .rd(lnk)
  );

  sri_tick #(.MS_CYC_P(MS_CYC_P)) u_tick (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .en(!pc_mode && !cfg_active && timer_ms >= TIMER_MIN_MS),
    .period_ms(timer_ms),
    .tick(tick)
  );

  always_comb
  begin
    next_state = state;
    if (rx_fire && rx_data == CH_EOT)
    begin
      next_state = S_ADDRH;
    end
    else if (rx_fire)
    begin
      unique case (state)
        S_ADDRH: next_state = S_ADDRL;
        S_ADDRL: next_state = S_CODEH;
        S_CODEH: next_state = S_CODEL;
        S_CODEL: next_state = S_ENQ;
        S_ENQ:
        begin
          if (!addr_hit)
          begin
            next_state = S_IDLE;
          end
          else if (rx_data != CH_ENQ)
          begin
            next_state = S_NAK;
          end
          else
          begin
            next_state = S_STX;
          end
        end
        default: next_state = state;
      endcase
    end
    else if (launch_print)
    begin
      next_state = compact_line_format ? S_SIGN : S_SPACE;
    end
    else if (wr_fire)
    begin
      unique case (state)
        S_STX: next_state = S_C1;
        S_C1: next_state = S_C2;
        S_C2: next_state = is_err ? S_EOT : (neg ? S_SIGN : S_DIGIT);
        S_SPACE: next_state = S_SIGN;
        S_SIGN: next_state = S_DIGIT;
        S_DIGIT:
        begin
          if (idx == LAST_DIGIT)
          begin
            next_state = !is_print ? S_ETX : (compact_line_format ? S_CR : S_LF);
          end
        end
        S_ETX: next_state = S_BCC;
        S_LF: next_state = S_CR;
        default: next_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= S_IDLE;
    end
    else if (ce)
    begin
      state <= next_state;
    end
  end

  // Request fields
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      addr_high_char <= '0;
      addr_low_char <= '0;
      regcode_high_char <= '0;
      regcode_low_char <= '0;
    end
    else if (rx_fire && rx_data != CH_EOT)
    begin
      unique case (state)
        S_ADDRH: addr_high_char <= rx_data;
        S_ADDRL: addr_low_char <= rx_data;
        S_CODEH: regcode_high_char <= rx_data;
        S_CODEL: regcode_low_char <= rx_data;
        default: ;
      endcase
    end
  end

  // Register selection: request code in PC mode, print code when idle in printer mode
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      reg_code <= '0;
    end
    else if (ce)
    begin
      if (rx_fire && state == S_CODEL && rx_data != CH_EOT)
      begin
        reg_code <= {regcode_high_char, rx_data};
      end
      else if (!pc_mode && state == S_IDLE)
      begin
        reg_code <= print_code;
      end
    end
  end

  // Value capture and reply kind at launch
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      val <= '0;
      neg <= 1'b0;
      is_print <= 1'b0;
      is_err <= 1'b0;
    end
    else if (launch_print)
    begin
      val <= reg_bcd;
      neg <= reg_neg;
      is_print <= 1'b1;
      is_err <= 1'b0;
    end
    else if (rx_fire && state == S_ENQ && next_state == S_STX)
    begin
      val <= reg_bcd;
      neg <= reg_neg;
      is_print <= 1'b0;
      is_err <= !code_ok;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      idx <= '0;
    end
    else if (launch_print)
    begin
      idx <= '0;
    end
    else if (wr_fire && state == S_C2)
    begin
      idx <= first_nz;
    end
    else if (wr_fire && state == S_DIGIT && idx != LAST_DIGIT)
    begin
      idx <= idx + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bcc <= '0;
    end
    else if (wr_fire)
    begin
      if (state == S_STX)
      begin
        bcc <= '0;
      end
      else if (state != S_BCC)
      begin
        bcc <= bcc ^ tx_char;
      end
    end
  end

  // Pending printer line; a new event in the launch cycle wins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      enter_q <= 1'b0;
      trig_q <= 1'b0;
      pend <= 1'b0;
    end
    else if (ce)
    begin
      enter_q <= enter_key;
      trig_q <= trig_in;
      if (tick || manual_ev)
      begin
        pend <= 1'b1;
      end
      else if (launch_print || pc_mode)
      begin
        pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bit_cycles <= BITCW'(CLK_HZ_P / BAUD_RATE[BAUD_SEL_DEF]);
    end
    else if (ce)
    begin
      bit_cycles <= (baud_sel > 3'h6) ? BITCW'(CLK_HZ_P / BAUD_RATE[BAUD_SEL_DEF])
                                      : BITCW'(CLK_HZ_P / BAUD_RATE[baud_sel]);
    end
  end

  sequence s_req_head;
    rx_fire && rx_data == CH_EOT;
  endsequence
  sequence s_bad_end;
    rx_fire && state == S_ENQ && addr_hit && rx_data != CH_ENQ && rx_data != CH_EOT;
  endsequence

  property p_eot_restart;
    @(posedge mclk) disable iff (rst) s_req_head |=> state == S_ADDRH;
  endproperty
  a_eot_restart: assert property (p_eot_restart) else $error("EOT did not restart parsing");
  property p_nak;
    @(posedge mclk) disable iff (rst) s_bad_end |=> state == S_NAK && chr.data == CH_NAK;
  endproperty
  a_nak: assert property (p_nak) else $error("bad terminator not answered by NAK");
  property p_silent;
    @(posedge mclk) disable iff (rst)
    (rx_fire && state == S_ENQ && !addr_hit && rx_data != CH_EOT) |=> state == S_IDLE;
  endproperty
  a_silent: assert property (p_silent) else $error("foreign address not ignored");
  property p_good_reply;
    @(posedge mclk) disable iff (rst)
    (rx_fire && state == S_ENQ && addr_hit && rx_data == CH_ENQ) |=> state == S_STX && chr.data == CH_STX;
  endproperty
  a_good_reply: assert property (p_good_reply) else $error("good request not answered by STX");
  property p_bcc;
    @(posedge mclk) disable iff (rst)
    (wr_fire && state == S_ETX) |=> state == S_BCC && chr.data == ($past(bcc) ^ CH_ETX);
  endproperty
  a_bcc: assert property (p_bcc) else $error("check char is not the running XOR");
  property p_lead;
    @(posedge mclk) disable iff (rst)
    (state == S_DIGIT && $past(state) != S_DIGIT && !is_print) |->
    (tx_char != CH_ZERO || idx == LAST_DIGIT) && (val >> (4 * (DIGITS - 32'(idx)))) == '0;
  endproperty
  a_lead: assert property (p_lead) else $error("leading zero sent");
  property p_err_nodata;
    @(posedge mclk) disable iff (rst) (state == S_C2 && is_err && wr_fire) |=> state == S_EOT;
  endproperty
  a_err_nodata: assert property (p_err_nodata) else $error("bad code reply carries data");
  property p_tick_pend;
    @(posedge mclk) disable iff (rst) (ce && tick) |=> pend;
  endproperty
  a_tick_pend: assert property (p_tick_pend) else $error("timer tick lost");
  property p_manual;
    @(posedge mclk) disable iff (rst) (ce && manual_ev) |=> pend;
  endproperty
  a_manual: assert property (p_manual) else $error("trigger edge lost");
  property p_format;
    @(posedge mclk) disable iff (rst) launch_print |=> (state == S_SPACE) == !$past(compact_line_format);
  endproperty
  a_format: assert property (p_format) else $error("printer line format wrong");
endmodule : sri_readout

// [sri_readout_tb.sv]
// Self-checking bench of the serial register readout block.
// Assumes sri_pkg, the design files and sri_host_model are compiled first.
`timescale 1ns/100ps
module sri_readout_tb;
  import sri_pkg::*;
  logic mclk = 0, rst = 1, ce = 1, rx_valid = 0, pc_mode = 0, compact_line_format = 0;
  logic cfg_active = 1, enter_key = 0, trig_in = 0, stall_en = 0, rneg = 0;
  logic [7:0] rx_data = 8'h00;
  logic [CODEW-1:0] print_code = 16'h3A31, bad_code = 16'hFFFF;
  logic [TMRW-1:0] timer_ms = 14'h0000;
  logic [3:0] unit_addr_tens = 4'h1, unit_addr_ones = 4'h1;
  logic [BAUDW-1:0] baud_sel = 3'h4;
  logic [VALW-1:0] rbcd = 24'h00_0000;
  logic line_valid, line_ready, busy;
  logic [7:0] line_data;
  logic [BITCW-1:0] bit_cycles;
  logic [CODEW-1:0] reg_code;
  logic [7:0] exq[$];
  int fails = 0, comparisons = 0;

  sri_readout #(.MS_CYC_P(10), .CLK_HZ_P(CLK_HZ)) sri_readout_inst (.mclk(mclk), .rst(rst), .ce(ce),
    .rx_valid(rx_valid), .rx_data(rx_data), .line_valid(line_valid), .line_data(line_data),
    .line_ready(line_ready), .pc_mode(pc_mode), .compact_line_format(compact_line_format),
    .print_code(print_code), .timer_ms(timer_ms), .cfg_active(cfg_active), .enter_key(enter_key),
    .trig_in(trig_in), .unit_addr_tens(unit_addr_tens), .unit_addr_ones(unit_addr_ones),
    .baud_sel(baud_sel), .bit_cycles(bit_cycles), .reg_code(reg_code), .reg_ok(reg_code !== bad_code),
    .reg_neg(rneg), .reg_bcd(rbcd), .busy(busy));
  sri_host_model sri_host_model_inst (.mclk(mclk), .stall_en(stall_en), .line_valid(line_valid),
    .line_data(line_data), .line_ready(line_ready));

  always #50 mclk = ~mclk;

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Waits until the sequencer and link fall quiet, then compares what the host got
  task automatic drain_cmp(string nm);
    int idle;
    int t;
    idle = 0;
    for (t = 0; t < 3000 && idle < 8; t++)
    begin
      @(negedge mclk);
      idle = (busy === 1'b0 && line_valid === 1'b0) ? idle + 1 : 0;
    end
    chk({nm, " quiet"}, 1, idle >= 8);
    chk({nm, " length"}, exq.size(), sri_host_model_inst.got.size());
    foreach (exq[k])
      if (k < sri_host_model_inst.got.size())
        chk({nm, " char"}, exq[k], sri_host_model_inst.got[k]);
    sri_host_model_inst.got.delete();
    $display("Test %s done", nm);
  endtask : drain_cmp

  task automatic req(logic [7:0] a1, logic [7:0] a2, logic [7:0] c1, logic [7:0] c2, logic [7:0] e);
    logic [7:0] s[6];
    s = '{CH_EOT, a1, a2, c1, c2, e};
    foreach (s[i])
    begin
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_data = s[i];
    end
    @(negedge mclk);
    rx_valid = 1'b0;
  endtask : req

  // Answer to a good request: leading zeros dropped, check char over code chars through ETX
  function automatic void mk_pc(logic [7:0] c1, logic [7:0] c2);
    logic [7:0] b;
    bit lead;
    exq = {CH_STX, c1, c2};
    if (rneg)
      exq.push_back(CH_MINUS);
    lead = 1;
    for (int i = 5; i >= 0; i--)
      if (!(lead && rbcd[i*4+:4] == 4'h0 && i > 0))
      begin
        lead = 0;
        exq.push_back({4'h3, rbcd[i*4+:4]});
      end
    exq.push_back(CH_ETX);
    b = 8'h00;
    foreach (exq[k])
      if (k > 0)
        b ^= exq[k];
    exq.push_back(b);
  endfunction : mk_pc

  function automatic void mk_pr(bit compact);
    exq = {};
    if (!compact)
      exq.push_back(CH_SPACE);
    exq.push_back(rneg ? CH_MINUS : CH_PLUS);
    for (int i = 5; i >= 0; i--)
      exq.push_back({4'h3, rbcd[i*4+:4]});
    if (!compact)
      exq.push_back(CH_LF);
    exq.push_back(CH_CR);
  endfunction : mk_pr

  task automatic rand_val(int lz);
    for (int i = 0; i < 6; i++)
      rbcd[i*4+:4] = (i >= 6 - lz) ? 4'h0 : 4'($urandom % 10);
    rneg = (rbcd != 0) && ($urandom % 2);
  endtask : rand_val

  initial
  begin
    logic [7:0] c1, c2;
    logic [7:0] at[5][2];
    bit ans[5];
    int len;
    void'($urandom(32'h015c1d7f));
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    chk("busy after reset", 0, busy);
    chk("line_valid after reset", 0, line_valid);
    chk("bit_cycles after reset", CLK_HZ / BAUD_RATE[BAUD_SEL_DEF], bit_cycles);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge mclk);
      baud_sel = 3'(i);
      repeat (3) @(negedge mclk);
      chk("bit_cycles", CLK_HZ / BAUD_RATE[i == 7 ? 4 : i], bit_cycles);
    end
    pc_mode = 1'b1;
    stall_en = 1'b1;
    for (int n = 0; n < 14; n++)
    begin
      rand_val(n % 7);
      c1 = 8'h30 + 8'($urandom % 16);
      c2 = 8'h30 + 8'($urandom % 16);
      req(8'h31, 8'h31, c1, c2, CH_ENQ);
      mk_pc(c1, c2);
      drain_cmp("pc read");
    end
    @(negedge mclk);
    rx_valid = 1'b1;
    rx_data = CH_EOT;
    @(negedge mclk);
    rx_data = 8'h32;
    req(8'h31, 8'h31, 8'h3A, 8'h31, CH_ENQ);
    mk_pc(8'h3A, 8'h31);
    drain_cmp("eot restart");
    req(8'h31, 8'h31, 8'h3A, 8'h31, 8'h41);
    exq = {CH_NAK};
    drain_cmp("bad terminator");
    bad_code = 16'h3A33;
    req(8'h31, 8'h31, 8'h3A, 8'h33, CH_ENQ);
    exq = {CH_STX, 8'h3A, 8'h33, CH_EOT};
    drain_cmp("unknown code");
    bad_code = 16'hFFFF;
    at = '{'{8'h31, 8'h31}, '{8'h32, 8'h33}, '{8'h30, 8'h31}, '{8'h31, 8'h30}, '{8'h31, 8'h32}};
    ans = '{1, 0, 1, 1, 0};
    foreach (ans[i])
    begin
      rand_val(1);
      req(at[i][0], at[i][1], 8'h3A, 8'h31, CH_ENQ);
      mk_pc(8'h3A, 8'h31);
      if (!ans[i])
        exq = {};
      drain_cmp("address match");
    end
    unit_addr_tens = 4'h2;
    unit_addr_ones = 4'h3;
    req(8'h32, 8'h33, 8'h3A, 8'h31, CH_ENQ);
    mk_pc(8'h3A, 8'h31);
    drain_cmp("own address");
    unit_addr_tens = 4'h0;
    req(8'h32, 8'h33, 8'h3A, 8'h31, CH_ENQ);
    exq = {};
    drain_cmp("zero digit address");
    req(8'h31, 8'h31, 8'h3A, 8'h31, CH_ENQ);
    mk_pc(8'h3A, 8'h31);
    drain_cmp("fallback address");
    unit_addr_tens = 4'h1;
    unit_addr_ones = 4'h1;
    pc_mode = 1'b0;
    cfg_active = 1'b0;
    for (int f = 0; f < 4; f++)
    begin
      rand_val(f);
      print_code = {8'h3A, 8'h30 + 8'(f)};
      compact_line_format = f[0];
      @(negedge mclk);
      if (f < 2)
        trig_in = 1'b1;
      else
        enter_key = 1'b1;
      repeat (3) @(negedge mclk);
      trig_in = 1'b0;
      enter_key = 1'b0;
      mk_pr(f[0]);
      drain_cmp("manual line");
      chk("printed register", {8'h3A, 8'h30 + 8'(f)}, reg_code);
    end
    timer_ms = 14'd10;
    repeat (350) @(negedge mclk);
    cfg_active = 1'b1;
    mk_pr(1'b1);
    len = exq.size();
    repeat (2)
      for (int k = 0; k < len; k++)
        exq.push_back(exq[k]);
    drain_cmp("cyclic lines");
    repeat (300) @(negedge mclk);
    chk("cyclic stop", 0, sri_host_model_inst.got.size());
    cfg_active = 1'b0;
    repeat (350) @(negedge mclk);
    cfg_active = 1'b1;
    repeat (100) @(negedge mclk);
    chk("cyclic whole lines", 0, sri_host_model_inst.got.size() % len);
    chk("cyclic count", 3 * len, sri_host_model_inst.got.size());
    mk_pr(1'b1);
    foreach (sri_host_model_inst.got[k])
      chk("cyclic char", exq[k % len], sri_host_model_inst.got[k]);
    $display("Test cyclic done");
    report_and_stop();
  end

  initial
  begin
    #(100ns * 40000);
    fails++;
    report_and_stop();
  end
endmodule : sri_readout_tb

// [sri_tick.sv]
// Serial timer: one-cycle tick every period_ms milliseconds while enabled.
// Assumes a millisecond prescale count given by the parent.
`timescale 1ns/100ps
module sri_tick #(
  parameter int MS_CYC_P = sri_pkg::MS_CYC
) (
  input wire logic mclk, // Device clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic en, // Timer running
  input wire logic [sri_pkg::TMRW-1:0] period_ms, // Period in ms
  output logic tick // One-cycle period pulse
);
  import sri_pkg::*;
  logic [23:0] pre;
  logic [TMRW-1:0] ms;
  logic ms_end;

  assign ms_end = (pre == 24'(MS_CYC_P - 1));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pre <= '0;
      ms <= '0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick <= 1'b0;
      if (!en)
      begin
        pre <= '0;
        ms <= '0;
      end
      else if (ms_end)
      begin
        pre <= '0;
        if (ms + 1'b1 >= period_ms)
        begin
          ms <= '0;
          tick <= 1'b1;
        end
        else
        begin
          ms <= ms + 1'b1;
        end
      end
      else
      begin
        pre <= pre + 1'b1;
      end
    end
  end
endmodule : sri_tick
